// *** hw/dpsf_defines.svh ***
`ifndef DPSF_DEFINES_SVH
`define DPSF_DEFINES_SVH

// Port geometry of the shared RAM
`define DPSF_ADDR_W     13
`define DPSF_DATA_W     9
`define DPSF_IDX_W      3
`define DPSF_NUM_FLAGS  8

// Flag levels: zero means taken, one means free
`define DPSF_FLAG_FREE  1'b1
`define DPSF_FLAG_TAKEN 1'b0

// Clock period and pin phase times, in ns
`define DPSF_CLK_NS     4
`define DPSF_SETUP_NS   8
`define DPSF_STROBE_NS  20
`define DPSF_GAP_NS     8

// Least times round up to whole cycles, never below one
`define DPSF_NS2CYC(t) (((((t) + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS) < 1) ? 1 : \
                        (((t) + `DPSF_CLK_NS - 1) / `DPSF_CLK_NS))
`define DPSF_SETUP_CYC  `DPSF_NS2CYC(`DPSF_SETUP_NS)
`define DPSF_STROBE_CYC `DPSF_NS2CYC(`DPSF_STROBE_NS)
`define DPSF_GAP_CYC    `DPSF_NS2CYC(`DPSF_GAP_NS)

// Counter widths and the default retry budget of a persistent claim
`define DPSF_CNT_W      8
`define DPSF_MAX_POLLS  16

`endif

// *** hw/dpsf_pkg.sv ***
`include "dpsf_defines.svh"

package dpsf_pkg;

  // Operations a user may request
  typedef enum logic [1:0] {
    DPSF_OP_INIT    = 2'h0,
    DPSF_OP_CLAIM   = 2'h1,
    DPSF_OP_RELEASE = 2'h2
  } dpsf_op_type;

  typedef struct packed {
    dpsf_op_type                 op;
    logic [`DPSF_IDX_W-1:0]      index;
    logic                        persist;
  } dpsf_cmd_type;

  typedef struct packed {
    logic                        granted;
    logic                        withdrawn;
    logic                        illegal;
  } dpsf_result_type;

  // One RAM port as seen from outside; data is a split two-way pin
  typedef struct packed {
    logic                        chip_enable_n;
    logic                        semaphore_select_n;
    logic                        output_enable_n;
    logic                        read_write_n;
    logic [`DPSF_ADDR_W-1:0]     address;
    logic [`DPSF_DATA_W-1:0]     data_out;
    logic                        data_oe;
  } dpsf_pins_type;

  // Phases of one pin cycle, Gray order
  typedef enum logic [1:0] {
    DPSF_PH_IDLE   = 2'h0,
    DPSF_PH_SETUP  = 2'h1,
    DPSF_PH_STROBE = 2'h3,
    DPSF_PH_GAP    = 2'h2
  } dpsf_phase_type;

  // Host sequencer states, Gray along idle, claim write, claim read, finish and back
  typedef enum logic [2:0] {
    DPSF_ST_IDLE     = 3'h0,
    DPSF_ST_CLAIM_WR = 3'h1,
    DPSF_ST_CLAIM_RD = 3'h3,
    DPSF_ST_FINISH   = 3'h2,
    DPSF_ST_WITHDRAW = 3'h7,
    DPSF_ST_INIT_WR  = 3'h4,
    DPSF_ST_RELEASE  = 3'h5
  } dpsf_state_type;

endpackage

// *** hw/dpsf_bus_cycle.sv ***
`include "dpsf_defines.svh"

module dpsf_bus_cycle
  import dpsf_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Cycle request
  input  wire logic                    start,
  input  wire logic                    is_write,
  input  wire logic [`DPSF_IDX_W-1:0]  index,
  input  wire logic                    wr_bit,
  // Cycle answer
  output logic                         done,
  output logic [`DPSF_DATA_W-1:0]      rdata,
  // RAM port pins
  output dpsf_pins_type                pins,
  input  wire logic [`DPSF_DATA_W-1:0] data_in
);

  dpsf_phase_type          phase;
  logic [`DPSF_CNT_W-1:0]  cnt;
  logic [`DPSF_CNT_W-1:0]  strobe_len;

  // Phase sequencing; the gap always drops both selects between cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase <= DPSF_PH_IDLE;
      cnt   <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      cnt  <= cnt + `DPSF_CNT_W'(1);
      unique case (phase)
        DPSF_PH_IDLE: begin
          cnt <= '0;
          if (start) begin
            phase <= DPSF_PH_SETUP;
          end
        end
        DPSF_PH_SETUP: if (cnt == `DPSF_CNT_W'(`DPSF_SETUP_CYC - 1)) begin
          phase <= DPSF_PH_STROBE;
          cnt   <= '0;
        end
        DPSF_PH_STROBE: if (cnt == `DPSF_CNT_W'(`DPSF_STROBE_CYC - 1)) begin
          phase <= DPSF_PH_GAP;
          cnt   <= '0;
        end
        DPSF_PH_GAP: if (cnt == `DPSF_CNT_W'(`DPSF_GAP_CYC - 1)) begin
          phase <= DPSF_PH_IDLE;
          done  <= 1'b1;
        end
      endcase
    end
  end

  // Pin drive; chip enable stays high so the array is never touched
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '{chip_enable_n: 1'b1, semaphore_select_n: 1'b1, output_enable_n: 1'b1,
                read_write_n: 1'b1, address: '0, data_out: '0, data_oe: 1'b0};
    end else begin
      pins.chip_enable_n <= 1'b1;
      unique case (phase)
        DPSF_PH_IDLE: begin
          pins.data_oe <= 1'b0;
          if (start) begin
            pins.semaphore_select_n <= 1'b0;
            pins.address  <= `DPSF_ADDR_W'(index);
            pins.data_out <= {`DPSF_DATA_W{wr_bit}};
            pins.data_oe  <= is_write;
          end
        end
        DPSF_PH_SETUP: if (cnt == `DPSF_CNT_W'(`DPSF_SETUP_CYC - 1)) begin
          pins.read_write_n    <= ~pins.data_oe;
          pins.output_enable_n <= pins.data_oe;
        end
        DPSF_PH_STROBE: if (cnt == `DPSF_CNT_W'(`DPSF_STROBE_CYC - 1)) begin
          // Drop both strobes and the select so the next read re-latches
          pins.read_write_n       <= 1'b1;
          pins.output_enable_n    <= 1'b1;
          pins.semaphore_select_n <= 1'b1;
        end
        DPSF_PH_GAP: begin
          // Data held through the gap for write hold time
          pins.data_oe <= pins.data_oe;
        end
      endcase
    end
  end

  // Read data captured at the end of the output-enable strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (phase == DPSF_PH_STROBE && !pins.data_oe &&
                 cnt == `DPSF_CNT_W'(`DPSF_STROBE_CYC - 1)) begin
      rdata <= data_in;
    end
  end

  // Helper: length of each active strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_len <= '0;
    end else if (!pins.output_enable_n || !pins.read_write_n) begin
      strobe_len <= strobe_len + `DPSF_CNT_W'(1);
    end else begin
      strobe_len <= '0;
    end
  end

  chip_enable_high_a: assert property (
    @(posedge clk) disable iff (rst) pins.chip_enable_n == 1'b1)
    else $error("chip enable driven low");

  select_between_reads_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(pins.output_enable_n) |-> pins.semaphore_select_n ##1 pins.semaphore_select_n)
    else $error("select not dropped after read strobe");

  strobe_length_a: assert property (
    @(posedge clk) disable iff (rst)
    ($rose(pins.output_enable_n) || $rose(pins.read_write_n)) |->
      strobe_len == `DPSF_CNT_W'(`DPSF_STROBE_CYC))
    else $error("strobe width wrong");

  upper_address_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    !pins.semaphore_select_n |-> pins.address[`DPSF_ADDR_W-1:`DPSF_IDX_W] == '0)
    else $error("upper address bits not zero in semaphore cycle");

  write_drives_data_a: assert property (
    @(posedge clk) disable iff (rst)
    !pins.read_write_n |-> pins.data_oe && pins.output_enable_n && !pins.semaphore_select_n)
    else $error("write strobe without driven data");

endmodule // dpsf_bus_cycle

// *** hw/dpsf_host.sv ***
`include "dpsf_defines.svh"

// What this block does
// - Flags are active low: write zero to claim, same port writes one to free.
// - Polling drops select or output enable between reads.
// - Claim by writing zero then reading back; zero means granted.
// - After a failed claim keep reading or withdraw by writing one.
// - No automatic reset; initialisation writes one to all eight flags.
// - Chip enable stays high while semaphore select is low.
module dpsf_host
  import dpsf_pkg::*;
#(
  parameter int MAX_POLLS = `DPSF_MAX_POLLS
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Command side
  input  wire logic                    cmd_valid,
  input  wire dpsf_cmd_type            cmd,
  output logic                         cmd_ready,
  // Answer side
  output logic                         rsp_valid,
  output dpsf_result_type              rsp,
  output logic [`DPSF_NUM_FLAGS-1:0]   owned_flags,
  // RAM port pins
  output dpsf_pins_type                pins,
  input  wire logic [`DPSF_DATA_W-1:0] data_in
);

  dpsf_state_type              state;
  logic [`DPSF_IDX_W-1:0]      idx;
  logic                        persist;
  logic [`DPSF_CNT_W-1:0]      polls;
  logic                        start;
  logic                        launched;
  logic                        cyc_done;
  logic [`DPSF_DATA_W-1:0]     cyc_rdata;
  logic                        cyc_write;
  logic                        cyc_bit;
  logic                        granted_now;
  logic                        frees_now;
  logic [`DPSF_IDX_W:0]        init_writes;

  // True when the current state spends its pin cycles writing a one
  function automatic logic writes_one(input dpsf_state_type s);
    return s == DPSF_ST_INIT_WR || s == DPSF_ST_RELEASE || s == DPSF_ST_WITHDRAW;
  endfunction

  // True when the current state runs a pin cycle at all
  function automatic logic runs_cycle(input dpsf_state_type s);
    return writes_one(s) || s == DPSF_ST_CLAIM_WR || s == DPSF_ST_CLAIM_RD;
  endfunction

  // Cycle kind and written bit follow the state
  assign cyc_write   = state != DPSF_ST_CLAIM_RD;
  assign cyc_bit     = writes_one(state) ? `DPSF_FLAG_FREE : `DPSF_FLAG_TAKEN;
  // Every data bit must read zero; a mixed word counts as a refusal
  assign granted_now = state == DPSF_ST_CLAIM_RD && cyc_done && cyc_rdata == '0;
  assign frees_now   = writes_one(state) && cyc_done;

  dpsf_bus_cycle u_cycle (
    .clk      (clk),
    .rst      (rst),
    .start    (start),
    .is_write (cyc_write),
    .index    (idx),
    .wr_bit   (cyc_bit),
    .done     (cyc_done),
    .rdata    (cyc_rdata),
    .pins     (pins),
    .data_in  (data_in)
  );

  // One pin cycle at a time; a repeat read or the next init write relaunches after done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start    <= 1'b0;
      launched <= 1'b0;
    end else begin
      start <= runs_cycle(state) && !launched && !start && !cyc_done;
      if (cyc_done) begin
        launched <= 1'b0;
      end else if (start) begin
        launched <= 1'b1;
      end
    end
  end

  // Sequencer: write before read on a claim, withdraw on give-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= DPSF_ST_IDLE;
      idx     <= '0;
      persist <= 1'b0;
      polls   <= '0;
    end else begin
      unique case (state)
        DPSF_ST_IDLE: if (cmd_valid && cmd_ready) begin
          idx     <= cmd.index;
          persist <= cmd.persist;
          polls   <= '0;
          unique case (cmd.op)
            DPSF_OP_INIT: begin
              idx   <= '0;
              state <= DPSF_ST_INIT_WR;
            end
            DPSF_OP_CLAIM:   state <= DPSF_ST_CLAIM_WR;
            DPSF_OP_RELEASE: state <= DPSF_ST_RELEASE;
            default:         state <= DPSF_ST_FINISH;
          endcase
        end
        DPSF_ST_INIT_WR: if (cyc_done) begin
          if (idx == `DPSF_IDX_W'(`DPSF_NUM_FLAGS - 1)) begin
            state <= DPSF_ST_FINISH;
          end else begin
            idx <= idx + `DPSF_IDX_W'(1);
          end
        end
        DPSF_ST_CLAIM_WR: if (cyc_done) begin
          state <= DPSF_ST_CLAIM_RD;
        end
        DPSF_ST_CLAIM_RD: if (cyc_done) begin
          if (granted_now) begin
            state <= DPSF_ST_FINISH;
          end else if (persist && polls < `DPSF_CNT_W'(MAX_POLLS - 1)) begin
            polls <= polls + `DPSF_CNT_W'(1);
          end else begin
            // Leaving a zero behind would hand over the token later
            state <= DPSF_ST_WITHDRAW;
          end
        end
        DPSF_ST_WITHDRAW: if (cyc_done) begin
          state <= DPSF_ST_FINISH;
        end
        DPSF_ST_RELEASE: if (cyc_done) begin
          state <= DPSF_ST_FINISH;
        end
        DPSF_ST_FINISH: state <= DPSF_ST_IDLE;
      endcase
    end
  end

  // Command handshake: one command at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_ready <= 1'b1;
    end else if (state == DPSF_ST_FINISH) begin
      cmd_ready <= 1'b1;
    end else if (cmd_valid && cmd_ready) begin
      cmd_ready <= 1'b0;
    end
  end

  // Outcome, cleared on accept and reported with a one-cycle strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp       <= '0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= state == DPSF_ST_FINISH;
      if (state == DPSF_ST_IDLE && cmd_valid && cmd_ready) begin
        rsp <= '{granted: 1'b0, withdrawn: 1'b0, illegal: cmd.op > DPSF_OP_RELEASE};
      end else if (granted_now) begin
        rsp.granted <= 1'b1;
      end else if (state == DPSF_ST_WITHDRAW && cyc_done) begin
        rsp.withdrawn <= 1'b1;
      end
    end
  end

  // Tokens this port holds, one tracker per flag
  for (genvar i = 0; i < `DPSF_NUM_FLAGS; i++) begin : g_owned
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        owned_flags[i] <= 1'b0;
      end else if (granted_now && idx == `DPSF_IDX_W'(i)) begin
        owned_flags[i] <= 1'b1;
      end else if (frees_now && idx == `DPSF_IDX_W'(i)) begin
        owned_flags[i] <= 1'b0;
      end
    end
  end

  // Helper: writes issued by the current initialisation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_writes <= '0;
    end else if (state == DPSF_ST_IDLE) begin
      init_writes <= '0;
    end else if (state == DPSF_ST_INIT_WR && cyc_done) begin
      init_writes <= init_writes + (`DPSF_IDX_W + 1)'(1);
    end
  end

  read_after_write_a: assert property (
    @(posedge clk) disable iff (rst)
    state == DPSF_ST_CLAIM_RD && $past(state) != DPSF_ST_CLAIM_RD |->
      $past(state) == DPSF_ST_CLAIM_WR)
    else $error("claim read not preceded by claim write");

  failed_claim_exit_a: assert property (
    @(posedge clk) disable iff (rst)
    state == DPSF_ST_CLAIM_RD && cyc_done && cyc_rdata != '0 |=>
      state == DPSF_ST_CLAIM_RD || state == DPSF_ST_WITHDRAW)
    else $error("failed claim neither retried nor withdrawn");

  withdraw_writes_one_a: assert property (
    @(posedge clk) disable iff (rst)
    state == DPSF_ST_WITHDRAW && start |=> pins.data_out[0] == `DPSF_FLAG_FREE && pins.data_oe)
    else $error("withdraw does not write one");

  init_all_flags_a: assert property (
    @(posedge clk) disable iff (rst)
    $past(state) == DPSF_ST_INIT_WR && state == DPSF_ST_FINISH |->
      init_writes == (`DPSF_IDX_W + 1)'(`DPSF_NUM_FLAGS))
    else $error("initialisation did not write every flag");

  grant_reported_a: assert property (
    @(posedge clk) disable iff (rst)
    granted_now |=> state == DPSF_ST_FINISH ##1 rsp_valid && rsp.granted && owned_flags[idx])
    else $error("grant not reported");

endmodule // dpsf_host

// *** verification/dpsf_sem_model.sv ***
`include "dpsf_defines.svh"

module dpsf_sem_model
  import dpsf_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Host-side port
  input  wire dpsf_pins_type           pins,
  output logic [`DPSF_DATA_W-1:0]      data_in,
  // Opposite port, driven by the bench
  input  wire logic                    oth_wr,
  input  wire logic [2:0]              oth_idx,
  input  wire logic                    oth_d,
  output logic [7:0]                   oth_flag,
  // Observation of the host side
  output logic [7:0]                   host_req,
  output logic [15:0]                  host_reads,
  output logic [15:0]                  pin_busy,
  output logic [15:0]                  viol
);
  timeunit 1ns;
  timeprecision 1ps;

  // Eight flags apart from any RAM: owner 0 none, 1 host, 2 opposite
  logic [1:0] owner [8];
  logic [7:0] req_o;
  logic [7:0] armed;
  logic       lat;
  logic       rd_prev;
  logic       sel;
  logic       host_rd;
  logic       host_wr;

  // Flag space picked by select; only the low index lines count
  assign sel     = !pins.semaphore_select_n;
  assign host_rd = sel && !pins.output_enable_n;
  assign host_wr = sel && !pins.read_write_n;

  // Latched value on every bit while reading, else the inverse as a float
  assign data_in = (host_rd && rd_prev) ? {9{lat}} : ~{9{lat}};

  // Opposite side reads zero only when it owns the token
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      oth_flag[i] = (owner[i] != 2'h2);
    end
  end

  // No reset: latches power up taken by the host, so init is required
  initial begin
    host_req = 8'h00;
    req_o = 8'hFF;
    armed = 8'h00;
    lat = 1'b1;
    rd_prev = 1'b0;
    host_reads = 16'h0000;
    pin_busy = 16'h0000;
    viol = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      owner[i] = 2'h1;
    end
  end

  // One write from either side into request latch and token
  task automatic put(input logic opp, input logic [2:0] i, input logic v);
    if (opp) req_o[i] = v;
    else host_req[i] = v;
    if (!v && owner[i] == 2'h0) begin
      owner[i] = opp ? 2'h2 : 2'h1;
    end else if (v && owner[i] == (opp ? 2'h2 : 2'h1)) begin
      // A pending zero on the far side takes the token at once
      owner[i] = (opp ? host_req[i] : req_o[i]) ? 2'h0 : (opp ? 2'h1 : 2'h2);
    end
  endtask

  // Host side first: the host wins a tie on the same edge
  always @(posedge clk) begin
    if (sel) pin_busy++;
    if (sel && !pins.chip_enable_n) viol++;
    if (host_wr && pins.chip_enable_n) begin
      put(1'b0, pins.address[2:0], pins.data_out[0]);
      armed[pins.address[2:0]] = !pins.data_out[0];
    end
    if (oth_wr) put(1'b1, oth_idx, oth_d);
    // Capture once at the start of a read, frozen until select or output enable drops
    if (host_rd && !rd_prev) begin
      lat = (owner[pins.address[2:0]] != 2'h1);
      host_reads++;
      if (!armed[pins.address[2:0]]) viol++;
    end
    rd_prev = host_rd;
  end
endmodule // dpsf_sem_model

// *** verification/dpsf_host_bench.sv ***
`include "dpsf_defines.svh"

module dpsf_host_bench
  import dpsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int POLLS = 4;

  logic                     clk;
  logic                     rst;
  logic                     cmd_valid;
  dpsf_cmd_type             cmd;
  logic                     cmd_ready;
  logic                     rsp_valid;
  dpsf_result_type          rsp;
  logic [7:0]               owned_flags;
  dpsf_pins_type            pins;
  logic [`DPSF_DATA_W-1:0]  data_in;
  logic                     oth_wr;
  logic [2:0]               oth_idx;
  logic                     oth_d;
  logic [7:0]               oth_flag;
  logic [7:0]               host_req;
  logic [15:0]              host_reads;
  logic [15:0]              pin_busy;
  logic [15:0]              viol;
  logic [15:0]              base;
  dpsf_result_type          got;
  int                       mismatches;
  int                       cmp_count;

  // Short poll budget keeps the exhausted-claim case brief
  dpsf_host #(.MAX_POLLS(POLLS)) dut_u (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .owned_flags(owned_flags), .pins(pins),
    .data_in(data_in)
  );

  dpsf_sem_model model_u (
    .clk(clk), .pins(pins), .data_in(data_in), .oth_wr(oth_wr), .oth_idx(oth_idx),
    .oth_d(oth_d), .oth_flag(oth_flag), .host_req(host_req), .host_reads(host_reads),
    .pin_busy(pin_busy), .viol(viol)
  );

  // Clock generator, 4 ns period
  always #2 clk = ~clk;

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One command, held until taken, then wait for its answer
  task automatic run(input dpsf_op_type op, input logic [2:0] i, input logic p);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, i, p};
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    if (n >= 500) begin
      mismatches++;
      conclude();
    end
    got = rsp;
  endtask

  // Opposite port write; settle before anyone looks
  task automatic oth(input logic [2:0] i, input logic v);
    @(posedge clk);
    oth_wr <= 1'b1;
    oth_idx <= i;
    oth_d <= v;
    @(posedge clk);
    oth_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_init();
    run(DPSF_OP_INIT, 3'h0, 1'b0);
    chk(16'(host_req), 16'h00FF);
    chk(16'(oth_flag), 16'h00FF);
  endtask

  task automatic t_claim();
    run(DPSF_OP_CLAIM, 3'h3, 1'b0);
    chk(16'(got), 16'h0004);
    chk(16'(owned_flags), 16'h0008);
    oth(3'h3, 1'b0);
    chk(16'(oth_flag), 16'h00FF);
    oth(3'h3, 1'b1);
  endtask

  task automatic t_refuse();
    oth(3'h5, 1'b0);
    run(DPSF_OP_CLAIM, 3'h5, 1'b0);
    chk(16'(got), 16'h0002);
    chk(16'(host_req[5]), 16'h0001);
  endtask

  // Far side frees the token while the host keeps polling
  task automatic t_persist();
    fork
      run(DPSF_OP_CLAIM, 3'h5, 1'b1);
      begin
        repeat (30) @(posedge clk);
        oth(3'h5, 1'b1);
      end
    join
    chk(16'(got), 16'h0004);
    chk(16'(owned_flags), 16'h0028);
  endtask

  task automatic t_exhaust();
    oth(3'h6, 1'b0);
    base = host_reads;
    run(DPSF_OP_CLAIM, 3'h6, 1'b1);
    chk(16'(got), 16'h0002);
    chk(host_reads - base, 16'(POLLS));
    chk(16'(host_req[6]), 16'h0001);
    oth(3'h6, 1'b1);
  endtask

  // Host write lands first, so the late far-side zero only waits
  task automatic t_race();
    fork
      run(DPSF_OP_CLAIM, 3'h2, 1'b0);
      begin
        repeat (8) @(posedge clk);
        oth(3'h2, 1'b0);
      end
    join
    chk(16'(got), 16'h0004);
    chk(16'(oth_flag[2]), 16'h0001);
    oth(3'h2, 1'b1);
  endtask

  task automatic t_release();
    run(DPSF_OP_RELEASE, 3'h3, 1'b0);
    chk(16'(owned_flags), 16'h0024);
    oth(3'h3, 1'b0);
    chk(16'(oth_flag[3]), 16'h0000);
    oth(3'h3, 1'b1);
    oth(3'h5, 1'b0);
    run(DPSF_OP_RELEASE, 3'h5, 1'b0);
    chk(16'(oth_flag[5]), 16'h0000);
    chk(16'(owned_flags), 16'h0004);
    oth(3'h5, 1'b1);
  endtask

  // Undefined op must leave the pins idle
  task automatic t_illegal();
    base = pin_busy;
    run(dpsf_op_type'(2'h3), 3'h0, 1'b0);
    chk(16'(got), 16'h0001);
    chk(pin_busy - base, 16'h0000);
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    oth_wr = 1'b0;
    oth_idx = 3'h0;
    oth_d = 1'b1;
    mismatches = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_claim();
    t_refuse();
    t_persist();
    t_exhaust();
    t_race();
    t_release();
    t_illegal();
    chk(viol, 16'h0000);
    conclude();
  end
endmodule // dpsf_host_bench
